// [rtl/sdi_pkg.sv]
// shared constants for the serial dac input link, both ends
package sdi_pkg;
    // word layout and code points
    localparam int           WORD_W     = 12;
    localparam int           FULL_DEN   = 4096;
    localparam int           BIP_DEN    = 2048;
    localparam logic [11:0]  CODE_ZERO  = 12'h000;
    localparam logic [11:0]  CODE_MID   = 12'h800;
    localparam logic [11:0]  CODE_FULL  = 12'hfff;
    localparam logic [3:0]   BITS_WORD  = 4'hc;
    // pin synchroniser depth
    localparam int           SYNC_STAGES = 2;
    // host register indices, byte address is four times the index
    localparam logic [1:0]   IDX_DATA_HI = 2'h0;
    localparam logic [1:0]   IDX_DATA_LO = 2'h1;
    localparam logic [1:0]   IDX_CTRL    = 2'h2;
    localparam logic [1:0]   IDX_STATUS  = 2'h3;
    // control register fields
    localparam int           CTRL_SEND   = 0;
    localparam int           CTRL_LOAD   = 1;
    localparam int           CTRL_CLEAR  = 2;
    localparam int           CTRL_TWOS   = 3;
    localparam int           CTRL_AUTO   = 4;
    localparam int           CTRL_SEL_LO = 5;
    localparam int           CTRL_SEL_HI = 6;
    localparam logic [7:0]   CTRL_RESET  = 8'h10;
    // status register fields
    localparam int           STAT_BUSY   = 0;
    localparam int           STAT_PEND   = 1;
    localparam int           STAT_LEFT_LO = 4;
    localparam int           STAT_LEFT_HI = 7;
    // strobe select codes
    localparam logic [1:0]   SEL_RISE_A = 2'h0;
    localparam logic [1:0]   SEL_RISE_B = 2'h1;
    localparam logic [1:0]   SEL_FALL_C = 2'h2;
    localparam logic [1:0]   SEL_RISE_D = 2'h3;
    // link timing: sys cycles per half link period, link cycles per phase
    localparam logic [1:0]   LINK_DIV_HALF = 2'h2;
    localparam logic [2:0]   HOLD_TICKS    = 3'h4;
endpackage

// [rtl/sdi_link_if.sv]
// link between the host controller and the serial dac input logic
`timescale 1ns/1ps
interface sdi_link_if;
    logic linkClk;
    logic linkRst;
    logic strobeRiseA;
    logic strobeRiseB;
    logic strobeFallC;
    logic strobeRiseD;
    logic loadNA;
    logic loadNB;
    logic clearDacN;
    logic serialBitIn;

    modport host (
        output linkClk, linkRst, strobeRiseA, strobeRiseB, strobeFallC,
        output strobeRiseD, loadNA, loadNB, clearDacN, serialBitIn
    );
    modport device (
        input  linkClk, linkRst, strobeRiseA, strobeRiseB, strobeFallC,
        input  strobeRiseD, loadNA, loadNB, clearDacN, serialBitIn
    );
endinterface

// [rtl/sdi_device.sv]
// serial dac input logic: shift register, dac register, code decoding
// Notes on behaviour
// - shift bits in on active edge, MSB first
// - clear low zeroes dac register, input kept
// - unipolar code is straight binary over 4096
// - bipolar code is offset binary, midscale zero
// - host inverts MSB of two's complement data
// - bit weights halve, first worth one half
// - host writes once per bit, shifting between
// - four MSBs low nibble, eight LSBs next
// - strobe from decoded write to one address
// - dac load from a load bit at that same address
// - host serial pin drives data, strobe two
// - host word right justified in sixteen bits
// - rising edges a b d, falling edge c
// - strobe held post-edge blocks further shifting
// - load when both loads low, clear high
`timescale 1ns/1ps
module sdi_device
    import sdi_pkg::*;
(
    // link from the host
    sdi_link_if.device         link,
    // user side, asynchronous to the link
    input  wire logic          bipolarMode,
    // decoded state
    output logic [11:0]        inputWord,
    output logic [11:0]        dacCode,
    output logic signed [13:0] outputNum,
    output logic               wordComplete,
    output logic [3:0]         shiftCount
);

    // pin vector order for the synchroniser
    localparam int PIN_A   = 0;
    localparam int PIN_B   = 1;
    localparam int PIN_C   = 2;
    localparam int PIN_D   = 3;
    localparam int PIN_LA  = 4;
    localparam int PIN_LB  = 5;
    localparam int PIN_CLR = 6;
    localparam int PIN_DAT = 7;
    localparam int PIN_MOD = 8;
    localparam int PIN_W   = 9;

    logic [PIN_W-1:0] pinMeta;
    logic [PIN_W-1:0] pinSync;
    logic [PIN_W-1:0] pinPrev;
    logic [PIN_W-1:0] pinRaw;
    logic             rstMeta;
    logic             rstSync;
    logic             edgeA;
    logic             edgeB;
    logic             edgeC;
    logic             edgeD;
    logic             shiftNow;
    logic             loadNow;
    logic [12:0]      weightNum;

    // binary weighting: first bit is half scale, each next bit half of that
    function automatic logic [12:0] weightSum(input logic [11:0] code);
        logic [12:0] sum;
        sum = 13'h0000;
        for (int i = 0; i < WORD_W; i++) begin
            if (code[WORD_W-1-i]) begin
                sum = sum + 13'(FULL_DEN >> (i + 1));
            end
        end
        return sum;
    endfunction

    // idle test for a strobe: a b d idle low, c idle high
    function automatic logic strobeIdle(input logic level, input logic fallType);
        return fallType ? level : ~level;
    endfunction

    assign pinRaw = {bipolarMode, link.serialBitIn, link.clearDacN,
                     link.loadNB, link.loadNA, link.strobeRiseD,
                     link.strobeFallC, link.strobeRiseB, link.strobeRiseA};

    // two flops on every pin; the first stage feeds only the second
    always_ff @(posedge link.linkClk) begin
        pinMeta <= pinRaw;
        pinSync <= pinMeta;
    end

    // previous synced level, for edge detection
    always_ff @(posedge link.linkClk) begin
        if (rstSync) begin
            pinPrev <= {PIN_W{1'b0}} | (PIN_W'(1) << PIN_C);
        end else begin
            pinPrev <= pinSync;
        end
    end

    // link reset crosses like any other pin
    always_ff @(posedge link.linkClk) begin
        rstMeta <= link.linkRst;
        rstSync <= rstMeta;
    end

    // edge detectors per strobe polarity
    assign edgeA = pinSync[PIN_A] & ~pinPrev[PIN_A];
    assign edgeB = pinSync[PIN_B] & ~pinPrev[PIN_B];
    assign edgeC = ~pinSync[PIN_C] & pinPrev[PIN_C];
    assign edgeD = pinSync[PIN_D] & ~pinPrev[PIN_D];

    // an edge counts only while every other strobe sits idle;
    // a strobe parked at its post-edge level locks the register
    always_comb begin
        shiftNow = 1'b0;
        if (edgeA && strobeIdle(pinSync[PIN_B], 1'b0) &&
            strobeIdle(pinSync[PIN_C], 1'b1) && strobeIdle(pinSync[PIN_D], 1'b0)) begin
            shiftNow = 1'b1;
        end
        if (edgeB && strobeIdle(pinSync[PIN_A], 1'b0) &&
            strobeIdle(pinSync[PIN_C], 1'b1) && strobeIdle(pinSync[PIN_D], 1'b0)) begin
            shiftNow = 1'b1;
        end
        if (edgeC && strobeIdle(pinSync[PIN_A], 1'b0) &&
            strobeIdle(pinSync[PIN_B], 1'b0) && strobeIdle(pinSync[PIN_D], 1'b0)) begin
            shiftNow = 1'b1;
        end
        if (edgeD && strobeIdle(pinSync[PIN_A], 1'b0) &&
            strobeIdle(pinSync[PIN_B], 1'b0) && strobeIdle(pinSync[PIN_C], 1'b1)) begin
            shiftNow = 1'b1;
        end
    end

    // input shift register; data bit is synced in step with the strobes
    always_ff @(posedge link.linkClk) begin
        if (rstSync) begin
            inputWord <= CODE_ZERO;
        end else if (shiftNow) begin
            inputWord <= {inputWord[WORD_W-2:0], pinSync[PIN_DAT]};
        end
    end

    // bits taken since the last transfer, saturating at a full word
    always_ff @(posedge link.linkClk) begin
        if (rstSync || loadNow) begin
            shiftCount <= 4'h0;
        end else if (shiftNow && shiftCount != BITS_WORD) begin
            shiftCount <= shiftCount + 4'h1;
        end
    end

    // full word flag; a new edge in the load cycle keeps it honest
    always_ff @(posedge link.linkClk) begin
        if (rstSync) begin
            wordComplete <= 1'b0;
        end else if (shiftNow && shiftCount == BITS_WORD - 4'h1) begin
            wordComplete <= 1'b1;
        end else if (loadNow) begin
            wordComplete <= 1'b0;
        end
    end

    // level sensitive transfer: both loads low and clear released
    assign loadNow = ~pinSync[PIN_LA] & ~pinSync[PIN_LB] & pinSync[PIN_CLR];

    // dac register; clear acts at once without the link clock,
    // release is not synchronised so the first load waits two edges
    always_ff @(posedge link.linkClk or negedge link.clearDacN) begin
        if (!link.clearDacN) begin
            dacCode <= CODE_ZERO;
        end else if (rstSync) begin
            dacCode <= CODE_ZERO;
        end else if (loadNow) begin
            dacCode <= inputWord;
        end
    end

    // numerator of the output fraction
    assign weightNum = weightSum(dacCode);

    // unipolar: code over 4096; bipolar: offset binary over 2048,
    // so midscale reads zero and all ones reads 2047
    always_ff @(posedge link.linkClk) begin
        if (pinSync[PIN_MOD]) begin
            outputNum <= $signed({1'b0, weightNum}) - $signed(14'(BIP_DEN));
        end else begin
            outputNum <= $signed({1'b0, weightNum});
        end
    end

endmodule // sdi_device

// [rtl/sdi_host.sv]
// host controller: register port, link clock divider, bit sequencer
`timescale 1ns/1ps
module sdi_host
    import sdi_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [7:0]       regRdData,
    // link to the device
    sdi_link_if.host         link
);

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b000_0001,
        ST_SETUP   = 7'b000_0010,
        ST_EDGE    = 7'b000_0100,
        ST_RELEASE = 7'b000_1000,
        ST_LOAD    = 7'b001_0000,
        ST_LOADREL = 7'b010_0000,
        ST_CLEAR   = 7'b100_0000
    } sdh_state_t;

    sdh_state_t  state;
    logic [1:0]  divCnt;
    logic        linkClkR;
    logic        tick;
    logic [2:0]  phaseCnt;
    logic        phaseDone;
    logic [2:0]  rstTicks;
    logic [11:0] dataWord;
    logic [7:0]  ctrl;
    logic        pendSend;
    logic        pendLoad;
    logic        pendClear;
    logic [11:0] shiftWord;
    logic [3:0]  bitsLeft;
    logic        regHit;
    logic [1:0]  regIdx;
    logic [1:0]  sel;

    assign regIdx = regAddr[3:2];
    assign regHit = (regAddr[1:0] == 2'h0);
    assign sel    = ctrl[CTRL_SEL_HI:CTRL_SEL_LO];

    // link clock divider; tick marks the falling edge, so pins move mid-low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            divCnt   <= 2'h0;
            linkClkR <= 1'b0;
        end else if (divCnt == LINK_DIV_HALF - 2'h1) begin
            divCnt   <= 2'h0;
            linkClkR <= ~linkClkR;
        end else begin
            divCnt   <= divCnt + 2'h1;
        end
    end
    assign tick = (divCnt == LINK_DIV_HALF - 2'h1) && linkClkR;

    // link reset spans a few link edges so the device sync sees it
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rstTicks <= 3'h0;
        end else if (tick && rstTicks != HOLD_TICKS) begin
            rstTicks <= rstTicks + 3'h1;
        end
    end

    // data word, four MSBs in the low nibble of the high byte
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dataWord <= CODE_ZERO;
        end else if (regWr && regHit && regIdx == IDX_DATA_HI) begin
            dataWord[11:8] <= regWrData[3:0];
        end else if (regWr && regHit && regIdx == IDX_DATA_LO) begin
            dataWord[7:0] <= regWrData;
        end
    end

    // control bits; command bits are kept as pending flags instead
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (regWr && regHit && regIdx == IDX_CTRL) begin
            ctrl <= regWrData & 8'h78;
        end
    end

    // pending commands: a new write wins over the take in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pendSend  <= 1'b0;
            pendLoad  <= 1'b0;
            pendClear <= 1'b0;
        end else begin
            if (regWr && regHit && regIdx == IDX_CTRL && regWrData[CTRL_SEND]) begin
                pendSend <= 1'b1;
            end else if (tick && state == ST_IDLE && rstTicks == HOLD_TICKS) begin
                pendSend <= 1'b0;
            end
            if (regWr && regHit && regIdx == IDX_CTRL && regWrData[CTRL_LOAD]) begin
                pendLoad <= 1'b1;
            end else if (tick && state == ST_IDLE && !pendSend && rstTicks == HOLD_TICKS) begin
                pendLoad <= 1'b0;
            end
            if (regWr && regHit && regIdx == IDX_CTRL && regWrData[CTRL_CLEAR]) begin
                pendClear <= 1'b1;
            end else if (tick && state == ST_IDLE && !pendSend && !pendLoad &&
                         rstTicks == HOLD_TICKS) begin
                pendClear <= 1'b0;
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !regRd || !regHit) begin
            regRdData <= 8'h00;
        end else begin
            case (regIdx)
                IDX_DATA_HI: regRdData <= {4'h0, dataWord[11:8]};
                IDX_DATA_LO: regRdData <= dataWord[7:0];
                IDX_CTRL:    regRdData <= ctrl;
                IDX_STATUS:  regRdData <= {bitsLeft, 2'h0,
                                           pendSend | pendLoad | pendClear,
                                           state != ST_IDLE};
                default:     regRdData <= 8'h00;
            endcase
        end
    end

    // phase length in link cycles
    assign phaseDone = (phaseCnt == HOLD_TICKS - 3'h1);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state == ST_IDLE) begin
            phaseCnt <= 3'h0;
        end else if (tick) begin
            phaseCnt <= phaseDone ? 3'h0 : phaseCnt + 3'h1;
        end
    end

    // sequencer: one strobe per bit, then a separate load cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            shiftWord <= CODE_ZERO;
            bitsLeft  <= 4'h0;
        end else if (tick) begin
            case (state)
                ST_IDLE: begin
                    if (rstTicks != HOLD_TICKS) begin
                        state <= ST_IDLE;
                    end else if (pendSend) begin
                        // two's complement input gets its MSB flipped
                        shiftWord <= dataWord ^ (ctrl[CTRL_TWOS] ? CODE_MID : CODE_ZERO);
                        bitsLeft  <= BITS_WORD;
                        state     <= ST_SETUP;
                    end else if (pendLoad) begin
                        state <= ST_LOAD;
                    end else if (pendClear) begin
                        state <= ST_CLEAR;
                    end
                end
                ST_SETUP:   if (phaseDone) state <= ST_EDGE;
                ST_EDGE:    if (phaseDone) state <= ST_RELEASE;
                ST_RELEASE: begin
                    if (phaseDone) begin
                        shiftWord <= {shiftWord[10:0], 1'b0};
                        bitsLeft  <= bitsLeft - 4'h1;
                        if (bitsLeft != 4'h1) begin
                            state <= ST_SETUP;
                        end else begin
                            state <= ctrl[CTRL_AUTO] ? ST_LOAD : ST_IDLE;
                        end
                    end
                end
                ST_LOAD:    if (phaseDone) state <= ST_LOADREL;
                ST_LOADREL: if (phaseDone) state <= ST_IDLE;
                ST_CLEAR:   if (phaseDone) state <= ST_IDLE;
                default:    state <= ST_IDLE;
            endcase
        end
    end

    // link pins from flops; unselected strobes stay idle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            link.linkRst     <= 1'b1;
            link.strobeRiseA <= 1'b0;
            link.strobeRiseB <= 1'b0;
            link.strobeFallC <= 1'b1;
            link.strobeRiseD <= 1'b0;
            link.loadNA      <= 1'b1;
            link.loadNB      <= 1'b1;
            link.clearDacN   <= 1'b1;
            link.serialBitIn <= 1'b0;
        end else begin
            link.linkRst     <= (rstTicks != HOLD_TICKS);
            link.strobeRiseA <= (state == ST_EDGE) && (sel == SEL_RISE_A);
            link.strobeRiseB <= (state == ST_EDGE) && (sel == SEL_RISE_B);
            link.strobeFallC <= !((state == ST_EDGE) && (sel == SEL_FALL_C));
            link.strobeRiseD <= (state == ST_EDGE) && (sel == SEL_RISE_D);
            link.loadNA      <= (state != ST_LOAD);
            link.loadNB      <= (state != ST_LOAD);
            link.clearDacN   <= (state != ST_CLEAR);
            link.serialBitIn <= shiftWord[WORD_W-1];
        end
    end

    assign link.linkClk = linkClkR;

endmodule // sdi_host

// [tb/sdi_props.sv]
// link checker: assertions on the host to device link and device state
`timescale 1ns/1ps
module sdi_props
    import sdi_pkg::*;
(
    // link signals
    input wire logic        linkClk,
    input wire logic        linkRst,
    input wire logic        strobeRiseA,
    input wire logic        strobeRiseB,
    input wire logic        strobeFallC,
    input wire logic        strobeRiseD,
    input wire logic        loadNA,
    input wire logic        loadNB,
    input wire logic        clearDacN,
    input wire logic        serialBitIn,
    // device state
    input wire logic [11:0] inputWord,
    input wire logic [11:0] dacCode,
    input wire logic [3:0]  shiftCount
);
    logic [11:0] prevWord;
    logic        anyActive;

    default clocking linkCb @(posedge linkClk); endclocking
    default disable iff (linkRst);

    // any strobe at its active level, falling strobe counts when low
    assign anyActive = strobeRiseA | strobeRiseB | ~strobeFallC | strobeRiseD;

    // previous word, so a shift can be compared bit by bit
    always_ff @(posedge linkClk) begin
        prevWord <= inputWord;
    end

    clear_zeroes_dac_a: assert property (!clearDacN |-> dacCode == CODE_ZERO)
        else $error("dac register not zero while clear low");
    clear_keeps_input_a: assert property (!clearDacN |-> $stable(inputWord))
        else $error("input word moved while clear low");
    shift_msb_first_a: assert property ($changed(inputWord)
        |-> inputWord[11:1] == prevWord[10:0] && inputWord[0] == serialBitIn)
        else $error("input word did not shift by one bit");
    count_capped_a: assert property (shiftCount <= BITS_WORD)
        else $error("shift count above word length");
    dac_held_a: assert property ((loadNA || loadNB) [*5]
        |-> dacCode == $past(dacCode) || dacCode == CODE_ZERO)
        else $error("dac register moved without load");
    dac_loaded_a: assert property ($fell(loadNA) && !loadNB && clearDacN
        |-> ##[2:4] dacCode == inputWord)
        else $error("dac register not loaded from input word");
    loads_paired_a: assert property (loadNA == loadNB)
        else $error("load pins differ");
    one_strobe_a: assert property ($onehot0({strobeRiseA, strobeRiseB,
        ~strobeFallC, strobeRiseD}))
        else $error("more than one strobe active");
    data_held_a: assert property (anyActive && $past(anyActive)
        |-> $stable(serialBitIn))
        else $error("serial bit changed under an active strobe");
    strobe_width_a: assert property ($rose(anyActive) |-> anyActive [*3])
        else $error("strobe pulse too short");
endmodule // sdi_props

// [tb/tb.sv]
// testbench: host and device joined, plus a bench driven second link
`timescale 1ns/1ps
module tb;
    import sdi_pkg::*;
    // clock, reset, register port
    logic               sys_clk;
    logic               sys_rst;
    logic [3:0]         regAddr;
    logic [7:0]         regWrData;
    logic               regWr;
    logic               regRd;
    logic [7:0]         regRdData;
    logic               bipolarMode;
    // device observations
    logic [11:0]        inputWord;
    logic [11:0]        dacCode;
    logic signed [13:0] outputNum;
    logic               wordComplete;
    logic [3:0]         shiftCount;
    logic [11:0]        inputWordB;
    logic               clkBEn;
    int                 fails;
    int                 comparisons;

    sdi_link_if link ();
    sdi_link_if linkB ();

    sdi_host u_sdi_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .link(link));
    sdi_device u_sdi_device (.link(link), .bipolarMode(bipolarMode), .inputWord(inputWord),
        .dacCode(dacCode), .outputNum(outputNum), .wordComplete(wordComplete),
        .shiftCount(shiftCount));
    // second device, its link broken on purpose by the bench
    sdi_device u_sdi_device_b (.link(linkB), .bipolarMode(1'b0), .inputWord(inputWordB),
        .dacCode(), .outputNum(), .wordComplete(), .shiftCount());
    sdi_props u_sdi_props (.linkClk(link.linkClk), .linkRst(link.linkRst),
        .strobeRiseA(link.strobeRiseA), .strobeRiseB(link.strobeRiseB),
        .strobeFallC(link.strobeFallC), .strobeRiseD(link.strobeRiseD),
        .loadNA(link.loadNA), .loadNB(link.loadNB), .clearDacN(link.clearDacN),
        .serialBitIn(link.serialBitIn), .inputWord(inputWord), .dacCode(dacCode),
        .shiftCount(shiftCount));

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // second link clock, offset in phase, still outside frames
    initial begin
        linkB.linkClk = 1'b0;
        #3.7;
        forever #6 linkB.linkClk = clkBEn ? ~linkB.linkClk : 1'b0;
    end

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected register data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_dev(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected device value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(posedge sys_clk);
        d = regRdData;
    endtask

    // poll status; the extra wait covers the device's pin synchroniser
    task automatic wait_idle();
        logic [7:0] st;
        int         n;
        st = 8'h03;
        n = 0;
        while ((st[STAT_BUSY] !== 1'b0 || st[STAT_PEND] !== 1'b0) && n < 3000) begin
            reg_read({IDX_STATUS, 2'b00}, st);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            $display("unexpected busy at %0t: got %h expected %h", $time, st, 8'h00);
        end
        repeat (40) @(posedge sys_clk);
    endtask

    task automatic send(input logic [11:0] w, input logic [7:0] ctrl);
        reg_write({IDX_DATA_HI, 2'b00}, {4'h0, w[11:8]});
        reg_write({IDX_DATA_LO, 2'b00}, w[7:0]);
        reg_write({IDX_CTRL, 2'b00}, ctrl | 8'h01);
        wait_idle();
    endtask

    task automatic t_regs();
        logic [7:0] d;
        reg_read({IDX_CTRL, 2'b00}, d);
        check_reg(d, CTRL_RESET);
        reg_write({IDX_DATA_HI, 2'b00}, 8'hab);
        reg_write({IDX_DATA_LO, 2'b00}, 8'h3c);
        reg_write(4'h5, 8'hc3);
        reg_read({IDX_DATA_HI, 2'b00}, d);
        check_reg(d, 8'h0b);
        reg_read({IDX_DATA_LO, 2'b00}, d);
        check_reg(d, 8'h3c);
        reg_read(4'h9, d);
        check_reg(d, 8'h00);
        $display("test registers done");
    endtask

    // every strobe select, auto load, unipolar code view
    task automatic t_strobes();
        logic [11:0] w [4] = '{12'ha5c, 12'h3f1, 12'h801, 12'h0fe};
        for (int s = 0; s < 4; s++) begin
            send(w[s], {1'b0, 2'(s), 5'h10});
            check_dev({2'b00, inputWord}, {2'b00, w[s]});
            check_dev({2'b00, dacCode}, {2'b00, w[s]});
            check_dev(outputNum, {2'b00, w[s]});
            check_dev({13'h0, wordComplete}, 14'h0);
        end
        $display("test strobes done");
    endtask

    // two words without load: oldest bits drop, count saturates
    task automatic t_manual();
        bipolarMode <= 1'b1;
        send(12'h123, 8'h00);
        send(12'h800, 8'h00);
        check_dev({2'b00, inputWord}, 14'h0800);
        check_dev({10'h0, shiftCount}, {10'h0, BITS_WORD});
        check_dev({13'h0, wordComplete}, 14'h1);
        check_dev({2'b00, dacCode}, 14'h00fe);
        reg_write({IDX_CTRL, 2'b00}, 8'h02);
        wait_idle();
        check_dev({2'b00, dacCode}, 14'h0800);
        check_dev(outputNum, 14'h0000);
        $display("test manual load done");
    endtask

    // host flips the msb of two's complement values
    task automatic t_twos();
        send(12'h7ff, 8'h18);
        check_dev({2'b00, dacCode}, 14'h0fff);
        check_dev(outputNum, 14'h07ff);
        send(12'h800, 8'h18);
        check_dev({2'b00, dacCode}, 14'h0000);
        check_dev(outputNum, 14'h3800);
        $display("test twos done");
    endtask

    task automatic t_clear();
        bipolarMode <= 1'b0;
        send(12'h5a5, 8'h10);
        reg_write({IDX_CTRL, 2'b00}, 8'h04);
        wait_idle();
        check_dev({2'b00, dacCode}, 14'h0000);
        check_dev({2'b00, inputWord}, 14'h05a5);
        $display("test clear done");
    endtask

    // one phase on the second link: act bits are a, b, c, d active
    task automatic phase_b(input logic [3:0] act, input logic bitVal);
        @(posedge linkB.linkClk);
        linkB.strobeRiseA <= act[0];
        linkB.strobeRiseB <= act[1];
        linkB.strobeFallC <= ~act[2];
        linkB.strobeRiseD <= act[3];
        linkB.serialBitIn <= bitVal;
        repeat (4) @(posedge linkB.linkClk);
    endtask

    task automatic t_block();
        clkBEn = 1'b1;
        repeat (4) @(posedge linkB.linkClk);
        linkB.linkRst <= 1'b0;
        phase_b(4'b0000, 1'b1);
        phase_b(4'b0001, 1'b1);
        phase_b(4'b0001, 1'b0);
        check_dev({2'b00, inputWordB}, 14'h0001);
        phase_b(4'b0011, 1'b0);
        phase_b(4'b0001, 1'b0);
        check_dev({2'b00, inputWordB}, 14'h0001);
        phase_b(4'b0000, 1'b0);
        phase_b(4'b0100, 1'b0);
        phase_b(4'b1100, 1'b1);
        phase_b(4'b0000, 1'b1);
        check_dev({2'b00, inputWordB}, 14'h0002);
        linkB.serialBitIn <= 1'b0;
        clkBEn = 1'b0;
        $display("test blocked strobes done");
    endtask

    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial begin
        fails = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        bipolarMode = 1'b0;
        clkBEn = 1'b0;
        {linkB.linkRst, linkB.loadNA, linkB.loadNB, linkB.clearDacN} = 4'hf;
        {linkB.strobeRiseA, linkB.strobeRiseB, linkB.strobeRiseD} = 3'h0;
        linkB.strobeFallC = 1'b1;
        linkB.serialBitIn = 1'b0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_strobes();
        t_manual();
        t_twos();
        t_clear();
        t_block();
        test_done();
    end

    // watchdog, well beyond the few thousand cycles the tests take
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        $display("unexpected timeout at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        test_done();
    end
endmodule // tb
